//--- src/fac_audio_clock_gen.sv
// field-locked audio clock generator with its control registers
`timescale 1ns/1ps

// Summary of operation
// - hold 18-bit master cycles per field
// - hold 22-bit nominal synthesis increment
// - bit clock divided from master clock
// - channel clock divided from bit clock
// - loop locks to field unless opened
// - field reference from decoder or expansion
// - channel clock moves on chosen bit edge
// - bit clock moves on chosen master edge
module fac_audio_clock_gen (
  input  wire logic                       clk_in,
  input  wire logic                       nrst_in,
  input  wire logic [fac_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [fac_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  input  wire logic                       internal_vref_in,
  input  wire logic                       expansion_vertical_ref_in,
  input  wire logic                       audio_master_clock_in,
  output logic      [fac_pkg::DATA_W-1:0] reg_rdata_out,
  output logic                            audio_master_clock_out,
  output logic                            serial_bit_clock_out,
  output logic                            channel_select_clock_out
);
  import fac_pkg::*;

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  logic [CPF_W-1:0]   cycles_per_field;
  logic [INC_W-1:0]   nominal_increment;
  logic [RATIO_W-1:0] bit_clock_divider;
  logic [RATIO_W-1:0] channel_clock_divider;
  logic [CTRL_W-1:0]  audio_clock_control;
  logic [DATA_W-1:0]  next_rdata;

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] sel,
                                  input logic              wr);
    wr_hit = wr && (a == sel);
  endfunction

  wire loop_open_select          = audio_clock_control[LOOP_OPEN_POS];
  wire vertical_reference_select = audio_clock_control[VREF_SEL_POS];
  wire channel_clock_phase       = audio_clock_control[CHAN_PHASE_POS];
  wire bit_clock_phase           = audio_clock_control[BIT_PHASE_POS];

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cycles_per_field      <= CPF_RST;
      nominal_increment     <= INC_RST;
      bit_clock_divider     <= RATIO_RST;
      channel_clock_divider <= RATIO_RST;
      audio_clock_control   <= CTRL_RST;
    end else begin
      if (wr_hit(reg_addr_in, ADDR_CPF_LOW, reg_wr_in)) begin
        cycles_per_field[7:0] <= reg_wdata_in;
      end else if (wr_hit(reg_addr_in, ADDR_CPF_MID, reg_wr_in)) begin
        cycles_per_field[15:8] <= reg_wdata_in;
      end else if (wr_hit(reg_addr_in, ADDR_CPF_HIGH, reg_wr_in)) begin
        cycles_per_field[CPF_W-1:16] <= reg_wdata_in[CPF_HW-1:0];
      end else if (wr_hit(reg_addr_in, ADDR_INC_LOW, reg_wr_in)) begin
        nominal_increment[7:0] <= reg_wdata_in;
      end else if (wr_hit(reg_addr_in, ADDR_INC_MID, reg_wr_in)) begin
        nominal_increment[15:8] <= reg_wdata_in;
      end else if (wr_hit(reg_addr_in, ADDR_INC_HIGH, reg_wr_in)) begin
        nominal_increment[INC_W-1:16] <= reg_wdata_in[INC_HW-1:0];
      end else if (wr_hit(reg_addr_in, ADDR_BIT_DIV, reg_wr_in)) begin
        bit_clock_divider <= reg_wdata_in[RATIO_W-1:0];
      end else if (wr_hit(reg_addr_in, ADDR_CHAN_DIV, reg_wr_in)) begin
        channel_clock_divider <= reg_wdata_in[RATIO_W-1:0];
      end else if (wr_hit(reg_addr_in, ADDR_CTRL, reg_wr_in)) begin
        audio_clock_control <= reg_wdata_in[CTRL_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // read path, unused bits and unmapped addresses read as zero
  // ----------------------------------------------------------------------
  fac_loop_t loop_state;
  wire       tracking = (loop_state == FAC_TRACK);

  always_comb begin
    next_rdata = '0;
    if (reg_addr_in == ADDR_CPF_LOW) begin
      next_rdata = cycles_per_field[7:0];
    end else if (reg_addr_in == ADDR_CPF_MID) begin
      next_rdata = cycles_per_field[15:8];
    end else if (reg_addr_in == ADDR_CPF_HIGH) begin
      next_rdata[CPF_HW-1:0] = cycles_per_field[CPF_W-1:16];
    end else if (reg_addr_in == ADDR_INC_LOW) begin
      next_rdata = nominal_increment[7:0];
    end else if (reg_addr_in == ADDR_INC_MID) begin
      next_rdata = nominal_increment[15:8];
    end else if (reg_addr_in == ADDR_INC_HIGH) begin
      next_rdata[INC_HW-1:0] = nominal_increment[INC_W-1:16];
    end else if (reg_addr_in == ADDR_BIT_DIV) begin
      next_rdata[RATIO_W-1:0] = bit_clock_divider;
    end else if (reg_addr_in == ADDR_CHAN_DIV) begin
      next_rdata[RATIO_W-1:0] = channel_clock_divider;
    end else if (reg_addr_in == ADDR_CTRL) begin
      next_rdata[CTRL_W-1:0] = audio_clock_control;
      next_rdata[TRACK_POS]  = tracking;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= RDATA_RST;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // pin synchronisers and field reference
  // ----------------------------------------------------------------------
  logic xrv_s1, xrv_s2;
  logic mx_s1, mx_s2, mx_s3;
  logic ref_prev;

  // internal reference is on our clock already, so it is not resampled
  wire ref_now = vertical_reference_select ? xrv_s2
                                           : internal_vref_in;
  wire field_pulse = ref_now && !ref_prev;
  wire mx_rise     = mx_s2 && !mx_s3;
  wire mx_fall     = !mx_s2 && mx_s3;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      xrv_s1   <= 1'b0;
      xrv_s2   <= 1'b0;
      mx_s1    <= 1'b0;
      mx_s2    <= 1'b0;
      mx_s3    <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      xrv_s1   <= expansion_vertical_ref_in;
      xrv_s2   <= xrv_s1;
      mx_s1    <= audio_master_clock_in;
      mx_s2    <= mx_s1;
      mx_s3    <= mx_s2;
      ref_prev <= ref_now;
    end
  end

  // ----------------------------------------------------------------------
  // master clock synthesis and field counting
  // ----------------------------------------------------------------------
  logic [ACC_W-1:0]  acc;
  logic              mclk_prev;
  logic [CPF_W-1:0]  field_count;
  logic [TRIM_W-1:0] trim;

  wire signed [SUM_W-1:0] inc_sum = $signed({2'b00, nominal_increment})
                                  + $signed({trim[TRIM_W-1], trim});
  // clamping keeps a large trim from wrapping the increment around
  wire [INC_W-1:0] inc_eff = inc_sum[SUM_W-1] ? '0
                           : (inc_sum[SUM_W-2:INC_W] != '0) ? INC_MAX
                           : inc_sum[INC_W-1:0];
  wire mclk_rise = acc[ACC_W-1] && !mclk_prev;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      acc         <= '0;
      mclk_prev   <= 1'b0;
      field_count <= '0;
    end else begin
      acc       <= acc + ACC_W'(inc_eff);
      mclk_prev <= acc[ACC_W-1];
      if (field_pulse) begin
        field_count <= mclk_rise ? CPF_W'(1) : '0;
      end else if (mclk_rise && field_count != CPF_MAX) begin
        field_count <= field_count + CPF_W'(1);
      end
    end
  end

  assign audio_master_clock_out = acc[ACC_W-1];

  // ----------------------------------------------------------------------
  // loop control
  // ----------------------------------------------------------------------
  fac_loop_t next_loop_state;
  wire signed [ERR_W-1:0] err = $signed({1'b0, cycles_per_field})
                              - $signed({1'b0, field_count});
  wire signed [SUM_W-1:0] trim_sum = $signed({trim[TRIM_W-1], trim})
                                   + SUM_W'(err);
  wire trim_hi = !trim_sum[SUM_W-1] && trim_sum[SUM_W-2];
  wire trim_lo = trim_sum[SUM_W-1] && !trim_sum[SUM_W-2];
  wire [TRIM_W-1:0] next_trim = trim_hi ? TRIM_MAX
                              : trim_lo ? TRIM_MIN
                              : trim_sum[TRIM_W-1:0];

  always_comb begin
    next_loop_state = loop_state;
    case (loop_state)
      FAC_OPEN: begin
        if (!loop_open_select) next_loop_state = FAC_FIRST;
      end
      // the first field after closing is partial, so it only starts counting
      FAC_FIRST: begin
        if (loop_open_select) next_loop_state = FAC_OPEN;
        else if (field_pulse) next_loop_state = FAC_TRACK;
      end
      FAC_TRACK: begin
        if (loop_open_select) next_loop_state = FAC_OPEN;
      end
      default: next_loop_state = FAC_OPEN;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      loop_state <= FAC_OPEN;
      trim       <= TRIM_RST;
    end else begin
      loop_state <= next_loop_state;
      if (loop_open_select) begin
        trim <= TRIM_RST;
      end else if (tracking && field_pulse) begin
        trim <= next_trim;
      end
    end
  end

  // ----------------------------------------------------------------------
  // bit and channel clock dividers
  // ----------------------------------------------------------------------
  wire bit_rise;
  wire bit_fall;

  fac_edge_divider u_bit_div (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .rise_in  (mx_rise),
    .fall_in  (mx_fall),
    .phase_in (bit_clock_phase),
    .ratio_in (bit_clock_divider),
    .clk_out  (serial_bit_clock_out),
    .rise_out (bit_rise),
    .fall_out (bit_fall)
  );

  fac_edge_divider u_chan_div (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .rise_in  (bit_rise),
    .fall_in  (bit_fall),
    .phase_in (channel_clock_phase),
    .ratio_in (channel_clock_divider),
    .clk_out  (channel_select_clock_out),
    .rise_out (),
    .fall_out ()
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  chk_cpf_write: assert property (
    reg_wr_in && reg_addr_in == ADDR_CPF_MID
    |=> cycles_per_field[15:8] == $past(reg_wdata_in))
    else $error("cycles per field mid byte not stored");

  chk_cpf_top_zero: assert property (
    reg_rd_in && reg_addr_in == ADDR_CPF_HIGH
    |=> reg_rdata_out[DATA_W-1:CPF_HW] == '0)
    else $error("unused cycles per field bits read nonzero");

  chk_inc_readback: assert property (
    reg_wr_in && reg_addr_in == ADDR_INC_HIGH ##1 !reg_wr_in
    ##1 reg_rd_in && reg_addr_in == ADDR_INC_HIGH && !reg_wr_in
    |=> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'h3f))
    else $error("increment top byte readback wrong");

  chk_open_trim: assert property (
    loop_open_select |=> trim == '0 && loop_state == FAC_OPEN)
    else $error("open loop still trimming");

  chk_vref_select: assert property (
    !vertical_reference_select && !internal_vref_in
    ##1 !vertical_reference_select && internal_vref_in |-> field_pulse)
    else $error("decoder reference pulse missed");

  chk_trim_hold: assert property (
    !field_pulse && !loop_open_select |=> $stable(trim))
    else $error("trim moved outside a field boundary");

  chk_trim_step: assert property (
    tracking && field_pulse && !loop_open_select
    && !trim_hi && !trim_lo
    |=> trim == $past(trim_sum[TRIM_W-1:0]))
    else $error("trim not corrected by field error");

  chk_div_write: assert property (
    reg_wr_in && reg_addr_in == ADDR_BIT_DIV
    |=> bit_clock_divider == $past(reg_wdata_in[RATIO_W-1:0]))
    else $error("bit clock ratio not stored");

  chk_chan_write: assert property (
    reg_wr_in && reg_addr_in == ADDR_CHAN_DIV
    |=> channel_clock_divider == $past(reg_wdata_in[RATIO_W-1:0]))
    else $error("channel clock ratio not stored");

  cov_tracking: cover property (loop_state == FAC_TRACK && field_pulse);
  cov_ext_ref: cover property (vertical_reference_select && field_pulse);
  cov_chan_edge: cover property ($rose(channel_select_clock_out));
  cov_reopen: cover property (tracking ##1 loop_open_select);

endmodule

//--- src/fac_edge_divider.sv
// divides a stream of edge pulses into a clock that moves on a chosen edge
`timescale 1ns/1ps

module fac_edge_divider
  import fac_pkg::*;
(
  input  wire logic                        clk_in,
  input  wire logic                        nrst_in,
  input  wire logic                        rise_in,
  input  wire logic                        fall_in,
  input  wire logic                        phase_in,
  input  wire logic [fac_pkg::RATIO_W-1:0] ratio_in,
  output logic                             clk_out,
  output logic                             rise_out,
  output logic                             fall_out
);

  logic [RATIO_W-1:0] cnt;
  wire                trig;
  wire [RATIO_W-1:0]  limit;
  wire [RATIO_W-1:0]  cnt_inc;
  wire                wrap;

  // a ratio of zero would stall the clock, so it acts as one
  assign limit   = (ratio_in == '0) ? RATIO_W'(1) : ratio_in;
  assign trig    = phase_in ? rise_in : fall_in;
  assign cnt_inc = cnt + RATIO_W'(1);
  assign wrap    = trig && (cnt_inc >= limit);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cnt      <= '0;
      clk_out  <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      rise_out <= wrap && !clk_out;
      fall_out <= wrap && clk_out;
      if (wrap) begin
        cnt     <= '0;
        clk_out <= !clk_out;
      end else if (trig) begin
        cnt <= cnt_inc;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_edge_phase: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    $changed(clk_out) |-> $past(phase_in ? rise_in : fall_in))
    else $error("divided clock moved on the wrong edge");

  chk_ratio_bound: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    $changed(clk_out) |-> ($past(cnt) >= $past(limit) - RATIO_W'(1)))
    else $error("divided clock toggled before ratio reached");

endmodule

//--- src/fac_pkg.sv
// constants and types shared by the field-locked audio clock generator
package fac_pkg;

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_CPF_LOW  = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_CPF_MID  = 8'h31;
  localparam logic [ADDR_W-1:0] ADDR_CPF_HIGH = 8'h32;
  localparam logic [ADDR_W-1:0] ADDR_INC_LOW  = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_INC_MID  = 8'h35;
  localparam logic [ADDR_W-1:0] ADDR_INC_HIGH = 8'h36;
  localparam logic [ADDR_W-1:0] ADDR_BIT_DIV  = 8'h38;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_DIV = 8'h39;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h3a;

  // ----------------------------------------------------------------------
  // field widths and layouts
  // ----------------------------------------------------------------------
  localparam int CPF_W   = 18;
  localparam int CPF_HW  = 2;
  localparam int INC_W   = 22;
  localparam int INC_HW  = 6;
  localparam int RATIO_W = 6;
  localparam int CTRL_W  = 4;
  localparam int ACC_W   = 23;
  localparam int ERR_W   = 19;
  localparam int TRIM_W  = 23;
  localparam int SUM_W   = 24;

  localparam int BIT_PHASE_POS  = 0;
  localparam int CHAN_PHASE_POS = 1;
  localparam int VREF_SEL_POS   = 2;
  localparam int LOOP_OPEN_POS  = 3;
  localparam int TRACK_POS      = 4;

  // ----------------------------------------------------------------------
  // reset values and saturation limits
  // ----------------------------------------------------------------------
  localparam logic [CPF_W-1:0]   CPF_RST   = 18'h0_0000;
  localparam logic [INC_W-1:0]   INC_RST   = 22'h00_0000;
  localparam logic [RATIO_W-1:0] RATIO_RST = 6'h01;
  localparam logic [CTRL_W-1:0]  CTRL_RST  = 4'h0;
  localparam logic [TRIM_W-1:0]  TRIM_RST  = 23'h00_0000;
  localparam logic [DATA_W-1:0]  RDATA_RST = 8'h00;

  localparam logic [INC_W-1:0]  INC_MAX  = 22'h3f_ffff;
  localparam logic [CPF_W-1:0]  CPF_MAX  = 18'h3_ffff;
  localparam logic [TRIM_W-1:0] TRIM_MAX = 23'h3f_ffff;
  localparam logic [TRIM_W-1:0] TRIM_MIN = 23'h40_0000;

  // ----------------------------------------------------------------------
  // loop states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FAC_OPEN  = 2'b00,
    FAC_FIRST = 2'b01,
    FAC_TRACK = 2'b10
  } fac_loop_t;

endpackage

//--- tb/fac_audio_partner.sv
// external audio device model: master clock source and frame listener
`timescale 1ns/1ps

module fac_audio_partner (
  input  wire logic       serial_bit_clock_in,
  input  wire logic       channel_select_clock_in,
  output logic            audio_master_clock_out,
  output logic      [7:0] bits_per_half_out
);
  logic [7:0] bit_cnt = 8'h00;
  logic [7:0] base    = 8'h00;

  // --------------------------------------------------------------------
  // master clock source
  // --------------------------------------------------------------------
  // odd start offset keeps the pin out of phase with the system clock
  initial begin
    audio_master_clock_out = 1'b0;
    #137;
    forever #400 audio_master_clock_out = ~audio_master_clock_out;
  end

  // --------------------------------------------------------------------
  // listener: bit clock rises counted per channel half
  // --------------------------------------------------------------------
  always @(posedge serial_bit_clock_in) begin
    bit_cnt = bit_cnt + 8'h01;
  end

  always @(channel_select_clock_in) begin
    bits_per_half_out = bit_cnt - base;
    base              = bit_cnt;
  end
endmodule

//--- tb/tb_fac_audio_clock_gen.sv
// self-checking bench for the field-locked audio clock generator
`timescale 1ns/1ps

module tb_fac_audio_clock_gen;
  import fac_pkg::*;

  logic              clk_in;
  logic              nrst_in;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic              vref_int;
  logic              vref_exp;
  logic              mclk_pin;
  logic [DATA_W-1:0] rdata;
  logic              mclk_out;
  logic              bclk;
  logic              cclk;
  logic [7:0]        bits_half;
  int                errors = 0;
  int                check_count = 0;
  int cyc = 0, pin_rise = 0, pin_fall = 0, bc_rise = 0, bc_fall = 0;
  int bc_period = 0, bc_rises = 0, cc_rise = 0, cc_period = 0;
  int cc_rises = 0, lag_pr = 0, lag_pf = 0, lag_br = 0, lag_bf = 0;
  int mo_cnt = 0;
  logic pin_q = 1'b0, bclk_q = 1'b0, cclk_q = 1'b0, mo_q = 1'b0;
  logic [7:0] ra [10] = '{ADDR_CPF_LOW, ADDR_CPF_MID, ADDR_CPF_HIGH,
    ADDR_INC_LOW, ADDR_INC_MID, ADDR_INC_HIGH, ADDR_BIT_DIV,
    ADDR_CHAN_DIV, ADDR_CTRL, 8'h33};
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h01, 8'h00, 8'h00};
  logic [7:0] rm [10] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h3f,
    8'h3f, 8'h3f, 8'h0f, 8'h00};

  fac_audio_clock_gen fac_audio_clock_gen_inst (
    .clk_in                   (clk_in),
    .nrst_in                  (nrst_in),
    .reg_addr_in              (addr),
    .reg_wdata_in             (wdata),
    .reg_wr_in                (wr),
    .reg_rd_in                (rd),
    .internal_vref_in         (vref_int),
    .expansion_vertical_ref_in(vref_exp),
    .audio_master_clock_in    (mclk_pin),
    .reg_rdata_out            (rdata),
    .audio_master_clock_out   (mclk_out),
    .serial_bit_clock_out     (bclk),
    .channel_select_clock_out (cclk)
  );

  fac_audio_partner fac_audio_partner_inst (
    .serial_bit_clock_in    (bclk),
    .channel_select_clock_in(cclk),
    .audio_master_clock_out (mclk_pin),
    .bits_per_half_out      (bits_half)
  );

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // --------------------------------------------------------------------
  // edge monitor, nonblocking so tasks read settled values at the edge
  // --------------------------------------------------------------------
  always @(posedge clk_in) begin
    cyc    <= cyc + 1;
    pin_q  <= mclk_pin;
    bclk_q <= bclk;
    cclk_q <= cclk;
    mo_q   <= mclk_out;
    if (mclk_pin && !pin_q) pin_rise <= cyc;
    if (!mclk_pin && pin_q) pin_fall <= cyc;
    if (bclk && !bclk_q) begin
      bc_rise   <= cyc;
      bc_period <= cyc - bc_rise;
      bc_rises  <= bc_rises + 1;
    end
    if (!bclk && bclk_q) bc_fall <= cyc;
    if (bclk !== bclk_q) begin
      lag_pr <= cyc - pin_rise;
      lag_pf <= cyc - pin_fall;
    end
    if (cclk && !cclk_q) begin
      cc_rise   <= cyc;
      cc_period <= cyc - cc_rise;
      cc_rises  <= cc_rises + 1;
    end
    if (cclk !== cclk_q) begin
      lag_br <= cyc - bc_rise;
      lag_bf <= cyc - bc_fall;
    end
    if (mclk_out && !mo_q) mo_cnt <= mo_cnt + 1;
    if (cyc == 60000) begin
      errors++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input int exp);
    check_count++;
    if (seen !== 32'(exp)) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, 32'(exp));
    end
  endtask

  task automatic results();
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // bus and stimulus helpers, entered and left at a rising edge
  // --------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    repeat (2) @(posedge clk_in);
    d = rdata;
  endtask

  task automatic pulse(input logic exp_sel);
    if (exp_sel) vref_exp <= 1'b1;
    else vref_int <= 1'b1;
    repeat (4) @(posedge clk_in);
    vref_int <= 1'b0;
    vref_exp <= 1'b0;
    repeat (100) @(posedge clk_in);
  endtask

  task automatic mo_edges(input int n, output int k);
    int s;
    repeat (4) @(posedge clk_in);
    s = mo_cnt;
    repeat (n) @(posedge clk_in);
    k = mo_cnt - s;
  endtask

  task automatic wait_bc();
    int s;
    s = bc_rises;
    for (int i = 0; i < 4000 && bc_rises < s + 3; i++) @(posedge clk_in);
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < 10; i++) begin
      rd_reg(ra[i], d);
      check(32'(d), int'(rv[i]));
      wr_reg(ra[i], 8'hff);
      rd_reg(ra[i], d);
      check(32'(d), int'(rm[i]));
    end
    for (int i = 0; i < 10; i++) begin
      rd_reg(ra[i], d);
      check(32'(d), int'(rm[i]));
    end
  endtask

  task automatic t_master();
    int k;
    wr_reg(ADDR_INC_LOW, 8'h00);
    wr_reg(ADDR_INC_MID, 8'h00);
    wr_reg(ADDR_INC_HIGH, 8'h10);
    mo_edges(80, k);
    check(32'(k), 10);
    // upper bits must be dropped, leaving 0x20 in the top byte
    wr_reg(ADDR_INC_HIGH, 8'he0);
    pulse(1'b0);
    pulse(1'b0);
    mo_edges(80, k);
    check(32'(k), 20);
  endtask

  task automatic t_lock();
    int k;
    wr_reg(ADDR_INC_HIGH, 8'h10);
    wr_reg(ADDR_CTRL, 8'h00);
    pulse(1'b0);
    mo_edges(80, k);
    check(32'(k), 10);
    pulse(1'b0);
    mo_edges(80, k);
    check(32'(k > 10), 1);
    wr_reg(ADDR_CTRL, 8'h08);
    mo_edges(80, k);
    check(32'(k), 10);
    wr_reg(ADDR_CTRL, 8'h04);
    repeat (3) pulse(1'b0);
    mo_edges(80, k);
    check(32'(k), 10);
    repeat (2) pulse(1'b1);
    mo_edges(80, k);
    check(32'(k > 10), 1);
  endtask

  task automatic t_bit();
    int nl [4] = '{0, 1, 3, 63};
    wr_reg(ADDR_CTRL, 8'h09);
    foreach (nl[i]) begin
      wr_reg(ADDR_BIT_DIV, 8'(nl[i]));
      wait_bc();
      check(32'(bc_period), ((nl[i] == 0) ? 1 : nl[i]) * 16);
      check(32'(lag_pr inside {[2:5]}), 1);
    end
    wr_reg(ADDR_BIT_DIV, 8'h01);
    wr_reg(ADDR_CTRL, 8'h08);
    wait_bc();
    check(32'(lag_pf inside {[2:5]}), 1);
  endtask

  task automatic t_chan();
    int ml [3] = '{1, 5, 0};
    int s;
    int m;
    wr_reg(ADDR_CTRL, 8'h0b);
    foreach (ml[i]) begin
      m = (ml[i] == 0) ? 1 : ml[i];
      wr_reg(ADDR_CHAN_DIV, 8'(ml[i]));
      s = cc_rises;
      for (int j = 0; j < 3000 && cc_rises < s + 3; j++) @(posedge clk_in);
      check(32'(cc_period), m * 32);
      check(32'(bits_half), m);
      check(32'(lag_br inside {[1:2]}), 1);
    end
    wr_reg(ADDR_CTRL, 8'h08);
    repeat (200) @(posedge clk_in);
    check(32'(lag_bf inside {[1:2]}), 1);
  endtask

  initial begin
    nrst_in  = 1'b0;
    addr     = 8'h00;
    wdata    = 8'h00;
    wr       = 1'b0;
    rd       = 1'b0;
    vref_int = 1'b0;
    vref_exp = 1'b0;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_master();
    t_lock();
    t_bit();
    t_chan();
    results();
  end
endmodule
